// ---- hw/pin_cell.sv ----
// one general-purpose pin: drive, input sync, polarity and alert
// assumes configuration bits come from ref_clk flops
module pin_cell (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic pin_in,
    input wire logic alert_enable,
    input wire logic direction,
    input wire logic polarity,
    input wire logic function_select,
    input wire logic out_value,
    output logic pin_out,
    output logic pin_oe,
    output logic active,
    output logic alert
);
    logic meta_q;
    logic level_q;
    logic out_q;
    logic oe_q;
    logic alert_q;
    logic active_w;

    // polarity 1 means active high, 0 active low
    assign active_w = polarity ? level_q : ~level_q;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            meta_q <= 1'b0;
            level_q <= 1'b0;
            out_q <= 1'b0;
            oe_q <= 1'b0;
            alert_q <= 1'b0;
        end else begin
            meta_q <= pin_in;
            level_q <= meta_q;
            out_q <= polarity ? out_value : ~out_value;
            oe_q <= function_select & ~direction;
            alert_q <= alert_enable & function_select & direction & active_w;
        end
    end

    assign pin_out = out_q;
    assign pin_oe = oe_q;
    assign active = active_w;
    assign alert = alert_q;
endmodule // pin_cell

// ---- hw/result_and_gpio_registers.sv ----
// result and general-purpose pin register bank behind a serial link
// assumes the host frames 16 bits with frame_sel_n low, msb first,
// and leaves a gap of at least 8 ref_clk cycles between frames
//
// Behaviour
// - aux results readable at 10011, 10100, 10101
// - battery results readable at 10110, 10111
// - temperature results readable at 11000, 11001
// - first pressure result readable at 11010
// - second pressure result holds 12-bit value
// - extended write: 1111, address, eight data bits
// - control a: write 0000, read 11011
// - control b: write 0001, read 11100
// - pin data: write 0010, read 11101
// - alert enable bits gate pin alerts
// - direction bit: 0 output, 1 input
// - polarity bit: 0 active low, 1 high
// - function select picks aux or pin
// - control b low nibble serves pin four
// - control b high nibble serves pin three
// - data bits 4..7 for pins four..one
// - all registers reset to zero
// - second pressure result readable at 10010
module result_and_gpio_registers
    import regbank_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic serial_clk,
    input wire logic frame_sel_n,
    input wire logic serial_in,
    output logic serial_out,
    input wire logic result_valid,
    input wire logic [4:0] result_addr,
    input wire logic [11:0] result_value,
    input wire logic [3:0] pin_in,
    output logic [3:0] pin_out,
    output logic [3:0] pin_oe,
    output logic [3:0] pin_alert,
    output logic [2:0] pin_function_select
);

    // link domain state
    logic link_rst;
    logic [CNT_W-1:0] bit_cnt_q;
    logic [FRAME_BITS-1:0] rx_q;
    logic [FRAME_BITS-1:0] word_q;
    logic wr_toggle_q;
    logic [RES_W-1:0] tx_shift_q;
    logic [RES_W-1:0] tx_hold_q;
    logic rd_pulse_link;
    logic [FRAME_BITS-1:0] rx_full;
    logic last_bit;
    logic load_tx;
    logic shift_tx;

    // core domain state
    core_state_type state_q;
    core_state_type state_d;
    logic wr_pulse;
    logic [RADDR_W-1:0] read_addr_q;
    logic [GPIO_W-1:0] ctl_a_q;
    logic [GPIO_W-1:0] ctl_b_q;
    logic [GPIO_W-1:0] data_q;
    logic [RES_W-1:0] res_q [RES_COUNT];
    logic [RES_W-1:0] rd_word_q;
    logic rd_toggle_q;

    // the frame select ends every frame itself, since the link clock
    // stops between frames and no edge is left to clear the counter
    assign link_rst = rst | frame_sel_n;
    assign rx_full = {rx_q[FRAME_BITS-2:0], serial_in};
    assign last_bit = bit_cnt_q == CNT_W'(FRAME_BITS - 1);
    assign load_tx = bit_cnt_q == CNT_W'(LEAD_BITS - 1);
    assign shift_tx = (bit_cnt_q >= CNT_W'(LEAD_BITS))
        && (bit_cnt_q < CNT_W'(FRAME_BITS));

    // bit counter and receive shifter, cleared outside frames
    always_ff @(posedge serial_clk or posedge link_rst) begin
        if (link_rst) begin
            bit_cnt_q <= '0;
            rx_q <= '0;
        end else if (bit_cnt_q != CNT_W'(FRAME_BITS)) begin
            bit_cnt_q <= bit_cnt_q + CNT_W'(1);
            rx_q <= rx_full;
        end
    end

    // transmit shifter: lead zeros, then 12 result bits msb first
    always_ff @(posedge serial_clk or posedge link_rst) begin
        if (link_rst) begin
            tx_shift_q <= '0;
        end else if (load_tx) begin
            tx_shift_q <= tx_hold_q;
        end else if (shift_tx) begin
            tx_shift_q <= {tx_shift_q[RES_W-2:0], 1'b0};
        end
    end

    // frame select clears the shifter, so the line idles low between
    // frames; a host must not read meaning into the idle level
    assign serial_out = tx_shift_q[RES_W-1];

    // complete word is held until the next frame ends, long after the
    // core has taken it through the toggle crossing
    always_ff @(posedge serial_clk or posedge rst) begin
        if (rst) begin
            word_q <= '0;
            wr_toggle_q <= 1'b0;
        end else if (last_bit) begin
            word_q <= rx_full;
            wr_toggle_q <= ~wr_toggle_q;
        end
    end

    // read snapshot arrives within the first three edges of a frame
    // and is loaded at edge four; a later one waits for the next frame
    toggle_pulse_sync u_rd_sync (
        .clk(serial_clk),
        .rst(rst),
        .toggle_in(rd_toggle_q),
        .pulse(rd_pulse_link)
    );

    always_ff @(posedge serial_clk or posedge rst) begin
        if (rst) begin
            tx_hold_q <= RES_RESET;
        end else if (rd_pulse_link) begin
            tx_hold_q <= rd_word_q;
        end
    end

    // word announcement into the ref_clk domain
    toggle_pulse_sync u_wr_sync (
        .clk(ref_clk),
        .rst(rst),
        .toggle_in(wr_toggle_q),
        .pulse(wr_pulse)
    );

    // write decode on the stable received word
    logic [3:0] waddr;
    logic [3:0] ext_addr;
    logic [GPIO_W-1:0] ext_data;
    logic apply;
    logic is_ext;
    logic wr_ctl_one;
    logic wr_ctl_a;
    logic wr_ctl_b;
    logic wr_data;

    // only control one and extended registers 0..2 are taken here;
    // every other write address belongs to logic outside this bank
    assign waddr = word_q[WADDR_MSB:WADDR_LSB];
    assign ext_addr = word_q[WADDR_LSB-1:EXT_ADDR_LSB];
    assign ext_data = word_q[GPIO_W-1:0];
    assign apply = state_q == ST_APPLY;
    assign is_ext = waddr == EXT_MAP;
    assign wr_ctl_one = apply && (waddr == WADDR_CONTROL_ONE);
    assign wr_ctl_a = apply && is_ext && (ext_addr == EXT_PIN_CONTROL_A);
    assign wr_ctl_b = apply && is_ext && (ext_addr == EXT_PIN_CONTROL_B);
    assign wr_data = apply && is_ext && (ext_addr == EXT_PIN_DATA);

    // sequence: take the word, then snapshot the addressed register
    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_IDLE: begin
                if (wr_pulse) begin
                    state_d = ST_APPLY;
                end
            end
            ST_APPLY: begin
                state_d = ST_SNAP;
            end
            ST_SNAP: begin
                state_d = ST_IDLE;
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state_q <= ST_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // read address latched from a control-one write
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            read_addr_q <= '0;
        end else if (wr_ctl_one) begin
            read_addr_q <= word_q[RADDR_LSB +: RADDR_W];
        end
    end

    // pin configuration and data; unused bits never store
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            ctl_a_q <= GPIO_RESET;
            ctl_b_q <= GPIO_RESET;
            data_q <= GPIO_RESET;
        end else begin
            if (wr_ctl_a) begin
                ctl_a_q <= ext_data;
            end
            if (wr_ctl_b) begin
                ctl_b_q <= ext_data & CTLB_WMASK;
            end
            if (wr_data) begin
                data_q <= ext_data & DATA_WMASK;
            end
        end
    end

    // conversion results; index is the read address minus the first
    logic res_hit;
    logic [4:0] res_index;

    // results outside the stored range are dropped, not wrapped;
    // back-to-back pulses each land, as there is no busy state
    assign res_hit = result_valid && (result_addr >= RD_PRESSURE_TWO)
        && (result_addr <= RD_PRESSURE_ONE);
    assign res_index = result_addr - RD_PRESSURE_TWO;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < RES_COUNT; i++) begin
                res_q[i] <= RES_RESET;
            end
        end else if (res_hit) begin
            res_q[res_index[3:0]] <= result_value;
        end
    end

    // per-pin field split; pin4 has no aux function
    logic [3:0] alert_en;
    logic [3:0] dir;
    logic [3:0] pol;
    logic [3:0] fsel;
    logic [3:0] out_val;
    logic [3:0] active;

    assign alert_en = {ctl_b_q[NIB_LO+ALERT_OFS], ctl_b_q[NIB_HI+ALERT_OFS],
        ctl_a_q[NIB_LO+ALERT_OFS], ctl_a_q[NIB_HI+ALERT_OFS]};
    assign dir = {ctl_b_q[NIB_LO+DIR_OFS], ctl_b_q[NIB_HI+DIR_OFS],
        ctl_a_q[NIB_LO+DIR_OFS], ctl_a_q[NIB_HI+DIR_OFS]};
    assign pol = {ctl_b_q[NIB_LO+POL_OFS], ctl_b_q[NIB_HI+POL_OFS],
        ctl_a_q[NIB_LO+POL_OFS], ctl_a_q[NIB_HI+POL_OFS]};
    assign fsel = {1'b1, ctl_b_q[NIB_HI+FSEL_OFS],
        ctl_a_q[NIB_LO+FSEL_OFS], ctl_a_q[NIB_HI+FSEL_OFS]};
    // pin four has no select bit, so only three selects leave the bank
    assign pin_function_select = fsel[2:0];

    // index 0 is pin one; pin n data sits at bit 8-n
    genvar gp;
    generate
        for (gp = 0; gp < PIN_COUNT; gp++) begin : g_pin
            assign out_val[gp] = data_q[DATA_PIN1-gp];
            pin_cell u_pin (
                .ref_clk(ref_clk),
                .rst(rst),
                .pin_in(pin_in[gp]),
                .alert_enable(alert_en[gp]),
                .direction(dir[gp]),
                .polarity(pol[gp]),
                .function_select(fsel[gp]),
                .out_value(out_val[gp]),
                .pin_out(pin_out[gp]),
                .pin_oe(pin_oe[gp]),
                .active(active[gp]),
                .alert(pin_alert[gp])
            );
        end
    endgenerate

    // data readback: input pins show the live active state
    logic [3:0] data_live;
    logic [GPIO_W-1:0] data_read;

    // an input pin reports its live active state so the host can poll it;
    // output and aux pins report the stored bit
    assign data_live = (dir & fsel & active) | (~(dir & fsel) & out_val);
    assign data_read = {data_live[0], data_live[1], data_live[2],
        data_live[3], 4'h0};

    // read selection; addresses outside this bank read zero
    logic [RES_W-1:0] rd_mux;
    logic rd_is_res;
    logic [4:0] rd_index;
    logic rd_sel_ctl_a;
    logic rd_sel_ctl_b;
    logic rd_sel_data;
    logic [RES_W-1:0] rd_res_word;
    logic [RES_W-1:0] rd_gpio_word;
    logic snap;

    // one named select per pin register, decoded from the latched address
    assign rd_index = read_addr_q - RD_PRESSURE_TWO;
    assign rd_is_res = (read_addr_q >= RD_PRESSURE_TWO)
        && (read_addr_q <= RD_PRESSURE_ONE);
    assign rd_sel_ctl_a = read_addr_q == RD_PIN_CONTROL_A;
    assign rd_sel_ctl_b = read_addr_q == RD_PIN_CONTROL_B;
    assign rd_sel_data = read_addr_q == RD_PIN_DATA;

    // the array is only indexed in range, so an unmapped address can
    // never pull an undefined element into the snapshot
    assign rd_res_word = rd_is_res ? res_q[rd_index[3:0]] : RES_RESET;

    // pin registers are eight bits; the upper nibble always reads zero
    assign rd_gpio_word =
        rd_sel_ctl_a ? {4'h0, ctl_a_q} :
        rd_sel_ctl_b ? {4'h0, ctl_b_q} :
        rd_sel_data ? {4'h0, data_read} :
        RES_RESET;

    // the two address ranges never overlap, so an or merges them
    assign rd_mux = rd_res_word | rd_gpio_word;
    assign snap = state_q == ST_SNAP;

    // a snapshot per frame keeps the crossing word still while the
    // link side picks it up; results that move later are seen next frame
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            rd_word_q <= RES_RESET;
            rd_toggle_q <= 1'b0;
        end else if (snap) begin
            rd_word_q <= rd_mux;
            rd_toggle_q <= ~rd_toggle_q;
        end
    end

endmodule // result_and_gpio_registers

// ---- hw/toggle_pulse_sync.sv ----
// toggle-to-pulse crossing: two flops, then an edge detect
// assumes the source toggles no faster than three destination edges
module toggle_pulse_sync (
    input wire logic clk,
    input wire logic rst,
    input wire logic toggle_in,
    output logic pulse
);
    logic meta_q;
    logic sync_q;
    logic seen_q;

    // first flop feeds only the second
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
            seen_q <= 1'b0;
        end else begin
            meta_q <= toggle_in;
            sync_q <= meta_q;
            seen_q <= sync_q;
        end
    end

    assign pulse = sync_q ^ seen_q;
endmodule // toggle_pulse_sync

// ---- shared/regbank_pkg.sv ----
// constants for the result and pin register bank and its serial link
// assumes 16-bit frames, msb first, sampled on the rising link clock edge
package regbank_pkg;
    localparam int FRAME_BITS = 16;
    localparam int CNT_W = 5;
    localparam int RES_W = 12;
    localparam int GPIO_W = 8;
    localparam int RADDR_W = 5;
    localparam int PIN_COUNT = 4;
    localparam int RES_COUNT = 9;
    localparam int LEAD_BITS = 4; // zero bits ahead of read data
    // frame layout
    localparam int WADDR_MSB = 15;
    localparam int WADDR_LSB = 12;
    localparam int EXT_ADDR_LSB = 8;
    localparam int RADDR_LSB = 7; // read address field in control one
    localparam logic [3:0] WADDR_CONTROL_ONE = 4'h1;
    localparam logic [3:0] EXT_MAP = 4'hF;
    localparam logic [3:0] EXT_PIN_CONTROL_A = 4'h0;
    localparam logic [3:0] EXT_PIN_CONTROL_B = 4'h1;
    localparam logic [3:0] EXT_PIN_DATA = 4'h2;
    // read addresses
    localparam logic [4:0] RD_PRESSURE_TWO = 5'h12;
    localparam logic [4:0] RD_AUX_IN_ONE = 5'h13;
    localparam logic [4:0] RD_AUX_IN_TWO = 5'h14;
    localparam logic [4:0] RD_AUX_IN_THREE = 5'h15;
    localparam logic [4:0] RD_BATTERY_ONE = 5'h16;
    localparam logic [4:0] RD_BATTERY_TWO = 5'h17;
    localparam logic [4:0] RD_TEMP_SINGLE_ENDED = 5'h18;
    localparam logic [4:0] RD_TEMP_DIFFERENTIAL = 5'h19;
    localparam logic [4:0] RD_PRESSURE_ONE = 5'h1A;
    localparam logic [4:0] RD_PIN_CONTROL_A = 5'h1B;
    localparam logic [4:0] RD_PIN_CONTROL_B = 5'h1C;
    localparam logic [4:0] RD_PIN_DATA = 5'h1D;
    // per-pin nibble: pin1 a[7:4], pin2 a[3:0], pin3 b[7:4], pin4 b[3:0]
    localparam int ALERT_OFS = 0;
    localparam int DIR_OFS = 1;
    localparam int POL_OFS = 2;
    localparam int FSEL_OFS = 3;
    localparam int NIB_HI = 4;
    localparam int NIB_LO = 0;
    localparam int DATA_PIN1 = 7; // pin n data at bit 8-n
    localparam logic [7:0] CTLB_WMASK = 8'hF7;
    localparam logic [7:0] DATA_WMASK = 8'hF0;
    localparam logic [11:0] RES_RESET = 12'h000;
    localparam logic [7:0] GPIO_RESET = 8'h00;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_APPLY = 3'b010,
        ST_SNAP = 3'b100
    } core_state_type;
endpackage

// ---- tb/regbank_monitor.sv ----
// checker for the result and pin register bank, bound to its top
// assumes the bank's port list; the link clock may stop between frames
module regbank_monitor (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic serial_clk,
    input wire logic frame_sel_n,
    input wire logic serial_in,
    input wire logic serial_out,
    input wire logic result_valid,
    input wire logic [4:0] result_addr,
    input wire logic [11:0] result_value,
    input wire logic [3:0] pin_in,
    input wire logic [3:0] pin_out,
    input wire logic [3:0] pin_oe,
    input wire logic [3:0] pin_alert,
    input wire logic [2:0] pin_function_select
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [4:0] frame_age_q;
    logic [4:0] pin_age_q;
    logic [2:0] lead_cnt_q;

    // ages saturate at 31: enough to tell a recent cause from none
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            frame_age_q <= 5'h1F;
            pin_age_q <= 5'h1F;
        end else begin
            frame_age_q <= !frame_sel_n ? 5'h00 : frame_age_q + {4'h0, frame_age_q != 5'h1F};
            pin_age_q <= $changed(pin_in) ? 5'h00 : pin_age_q + {4'h0, pin_age_q != 5'h1F};
        end
    end

    // edge count inside a frame, cleared when the host deselects
    always_ff @(posedge serial_clk or posedge frame_sel_n) begin
        if (frame_sel_n) begin
            lead_cnt_q <= 3'h0;
        end else if (lead_cnt_q != 3'h4) begin
            lead_cnt_q <= lead_cnt_q + 3'h1;
        end
    end

    a_reset_clean: assert property (@(posedge ref_clk) disable iff (rst)
        $fell(rst) |-> pin_oe == 4'h0 && pin_alert == 4'h0 && pin_function_select == 3'h0)
        else $error("pin outputs not quiet after reset");
    a_oe_needs_select: assert property (@(posedge ref_clk) disable iff (rst)
        (pin_oe[2:0] & ~$past(pin_function_select)) == 3'h0)
        else $error("pin driven while set to aux");
    a_alert_needs_select: assert property (@(posedge ref_clk) disable iff (rst)
        (pin_alert[2:0] & ~$past(pin_function_select)) == 3'h0)
        else $error("alert from a pin set to aux");
    a_dir_exclusive: assert property (@(posedge ref_clk) disable iff (rst)
        (pin_oe & pin_alert) == 4'h0)
        else $error("pin both driven and alerting");
    a_idle_out_low: assert property (@(posedge ref_clk) disable iff (rst)
        frame_sel_n && $past(frame_sel_n) |-> !serial_out)
        else $error("serial out high between frames");
    a_lead_bits_zero: assert property (@(posedge serial_clk)
        disable iff (rst || frame_sel_n) lead_cnt_q < 3'h4 |-> !serial_out)
        else $error("lead bit of read data not zero");
    a_config_needs_frame: assert property (@(posedge ref_clk) disable iff (rst)
        $changed({pin_out, pin_oe, pin_function_select}) |-> frame_age_q < 5'h10)
        else $error("pin setup changed without a frame");
    a_alert_needs_cause: assert property (@(posedge ref_clk) disable iff (rst)
        $changed(pin_alert) |-> frame_age_q < 5'h10 || pin_age_q < 5'h06)
        else $error("alert changed without cause");
endmodule // regbank_monitor

// ---- tb/result_and_gpio_registers_tb.sv ----
// bench for the result and pin register bank
// assumes the host model spaces frames; pins see a resolved wire level
module result_and_gpio_registers_tb
    import regbank_pkg::*;
();
    timeunit 1ns;
    timeprecision 100ps;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic serial_clk, frame_sel_n, serial_in, serial_out;
    logic result_valid = 1'b0;
    logic [4:0] result_addr = 5'h00;
    logic [11:0] result_value = 12'h000;
    logic [3:0] ext_level = 4'h0;
    logic [3:0] pin_out, pin_oe, pin_alert;
    logic [2:0] pin_function_select;
    wire logic [3:0] pin_in;
    int mismatches = 0;
    int samples_checked = 0;
    int cycles = 0;

    // wire level: an enabled driver wins, else the outside level
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_level);
    always #4 ref_clk = ~ref_clk;

    result_and_gpio_registers u_result_and_gpio_registers (.ref_clk(ref_clk), .rst(rst),
        .serial_clk(serial_clk), .frame_sel_n(frame_sel_n), .serial_in(serial_in),
        .serial_out(serial_out), .result_valid(result_valid), .result_addr(result_addr),
        .result_value(result_value), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
        .pin_alert(pin_alert), .pin_function_select(pin_function_select));
    serial_host_model u_serial_host_model (.serial_clk(serial_clk),
        .frame_sel_n(frame_sel_n), .serial_in(serial_in), .serial_out(serial_out));

    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // read takes two frames: the first selects, the second returns
    task automatic chk_reg(input string what, input logic [4:0] addr, input logic [15:0] exp);
        logic [15:0] val;
        u_serial_host_model.xfer({WADDR_CONTROL_ONE, addr, 7'h00}, val);
        u_serial_host_model.xfer({WADDR_CONTROL_ONE, addr, 7'h00}, val);
        chk(what, val, exp);
    endtask

    task automatic wr_ext(input logic [3:0] sel, input logic [7:0] data);
        logic [15:0] unused;
        u_serial_host_model.xfer({EXT_MAP, sel, data}, unused);
    endtask

    task automatic end_sim();
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // unmapped addresses 11, 1E, 1F included
    task automatic test_reset_values();
        for (int a = 5'h11; a <= 5'h1F; a++) begin
            chk_reg("reset read", 5'(a), 16'h0000);
        end
    endtask

    // back-to-back result pulses, then every result read back
    task automatic test_results();
        logic [4:0] addr;
        logic [15:0] rexp;
        for (int i = 0; i < 9; i++) begin
            @(posedge ref_clk);
            result_valid <= 1'b1;
            result_addr <= RD_PRESSURE_TWO + 5'(i);
            result_value <= 12'hA50 ^ 12'(i * 12'h111);
        end
        @(posedge ref_clk);
        result_valid <= 1'b0;
        for (int i = 0; i < 9; i++) begin
            addr = RD_PRESSURE_TWO + 5'(i);
            rexp = {4'h0, 12'hA50 ^ 12'(i * 12'h111)};
            chk_reg("result", addr, rexp);
        end
    endtask

    task automatic test_pins();
        wr_ext(EXT_PIN_CONTROL_A, 8'hCC);
        wr_ext(EXT_PIN_CONTROL_B, 8'hCF);
        wr_ext(EXT_PIN_DATA, 8'hFF);
        chk_reg("ctl a", RD_PIN_CONTROL_A, 16'h00CC);
        chk_reg("ctl b", RD_PIN_CONTROL_B, 16'h00C7);
        chk_reg("data", RD_PIN_DATA, 16'h00E0);
        chk("oe", {12'h000, pin_oe}, 16'h0007);
        chk("fsel", {13'h0000, pin_function_select}, 16'h0007);
        chk("drive", {12'h000, pin_out & pin_oe}, 16'h0007);
        chk("alert", {12'h000, pin_alert}, 16'h0000);
        @(posedge ref_clk);
        ext_level <= 4'h8;
        repeat (5) @(posedge ref_clk);
        chk("alert", {12'h000, pin_alert}, 16'h0008);
        chk_reg("data live", RD_PIN_DATA, 16'h00F0);
        wr_ext(EXT_PIN_CONTROL_B, 8'hC3);
        chk("alert", {12'h000, pin_alert}, 16'h0000);
        @(posedge ref_clk);
        ext_level <= 4'h0;
        repeat (5) @(posedge ref_clk);
        chk("alert", {12'h000, pin_alert}, 16'h0008);
        wr_ext(EXT_PIN_CONTROL_B, 8'hC2);
        chk("alert", {12'h000, pin_alert}, 16'h0000);
        wr_ext(EXT_PIN_CONTROL_A, 8'h88);
        chk("drive", {12'h000, pin_out & pin_oe}, 16'h0004);
        wr_ext(4'h3, 8'h00);
        chk_reg("ctl a", RD_PIN_CONTROL_A, 16'h0088);
        // pin one alerting input and pin two output, both set to aux
        wr_ext(EXT_PIN_CONTROL_A, 8'h30);
        chk("oe", {12'h000, pin_oe}, 16'h0004);
        chk("fsel", {13'h0000, pin_function_select}, 16'h0004);
        chk("alert", {12'h000, pin_alert}, 16'h0000);
    endtask

    // second reset in mid-run clears setup and results
    task automatic test_mid_reset();
        @(posedge ref_clk);
        rst <= 1'b1;
        repeat (5) @(posedge ref_clk);
        rst <= 1'b0;
        chk("oe", {12'h000, pin_oe}, 16'h0000);
        chk_reg("ctl a", RD_PIN_CONTROL_A, 16'h0000);
        chk_reg("aux one", RD_AUX_IN_ONE, 16'h0000);
    endtask

    initial begin
        repeat (5) @(posedge ref_clk);
        rst <= 1'b0;
        test_reset_values();
        test_results();
        test_pins();
        test_mid_reset();
        end_sim();
    end

    // hang guard, several times the expected run
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            mismatches++;
            end_sim();
        end
    end
endmodule // result_and_gpio_registers_tb

bind result_and_gpio_registers regbank_monitor u_regbank_monitor (.ref_clk(ref_clk),
    .rst(rst), .serial_clk(serial_clk), .frame_sel_n(frame_sel_n), .serial_in(serial_in),
    .serial_out(serial_out), .result_valid(result_valid), .result_addr(result_addr),
    .result_value(result_value), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
    .pin_alert(pin_alert), .pin_function_select(pin_function_select));

// ---- tb/serial_host_model.sv ----
// host on the serial link: 16-bit frames, msb first
// assumes the caller waits for xfer to return before the next frame
module serial_host_model (
    output logic serial_clk,
    output logic frame_sel_n,
    output logic serial_in,
    input wire logic serial_out
);
    timeunit 1ns;
    timeprecision 100ps;

    initial begin
        serial_clk = 1'b0;
        frame_sel_n = 1'b1;
        serial_in = 1'b1;
    end

    // one frame, 12 ns per bit; clock stands still outside it
    task automatic xfer(input logic [15:0] word, output logic [15:0] rdata);
        #3 frame_sel_n = 1'b0;
        for (int k = 15; k >= 0; k--) begin
            serial_in = word[k];
            #6 rdata[k] = serial_out;
            serial_clk = 1'b1;
            #6 serial_clk = 1'b0;
        end
        #3 frame_sel_n = 1'b1;
        serial_in = ~serial_in; // released line shows no stale bit
        #120; // gap well above the 64 ns the core needs
    endtask
endmodule // serial_host_model
